//--- include/fte_regs.vh
// Register map, field positions and codes of the tag and exception unit.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef FTE_REGS_VH
`define FTE_REGS_VH
// Register offsets
`define FTE_CTRL 8'h00
`define FTE_STAT 8'h04
`define FTE_IMASK 8'h08
`define FTE_TAG 8'h0c
`define FTE_CMD 8'h10
`define FTE_RES_LO 8'h14
`define FTE_RES_HI 8'h18
`define FTE_RES_EX 8'h1c
`define FTE_NRM_LO 8'h20
`define FTE_NRM_HI 8'h24
`define FTE_NRM_EX 8'h28
`define FTE_DATA 2'h1
// Control fields
`define FTE_CTRL_RST 12'h37f
`define FTE_IM 0
`define FTE_DM 1
`define FTE_OM 3
`define FTE_UM 4
`define FTE_PC 8
`define FTE_RC 10
// Status bits
`define FTE_IE 0
`define FTE_DE 1
`define FTE_OE 3
`define FTE_UE 4
`define FTE_PE 5
`define FTE_SF 6
`define FTE_C1 9
// Operand classes
`define FTE_CL_ZERO 3'h0
`define FTE_CL_NORM 3'h1
`define FTE_CL_DEN 3'h2
`define FTE_CL_INF 3'h3
`define FTE_CL_QUIET_NAN 3'h4
`define FTE_CL_SIGNALING_NAN 3'h5
`define FTE_CL_UNS 3'h6
// Tag codes
`define FTE_TG_VALID 2'h0
`define FTE_TG_ZERO 2'h1
`define FTE_TG_SPEC 2'h2
`define FTE_TG_EMPTY 2'h3
// Command codes
`define FTE_OP_ARITH 4'h1
`define FTE_OP_CMP 4'h2
`define FTE_OP_STINT 4'h3
`define FTE_OP_STDEC 4'h4
`define FTE_OP_TRANS 4'h5
`define FTE_OP_SPLIT 4'h6
`define FTE_OP_FINAL 4'h7
`define FTE_OP_PUSH 4'h8
// Exponent figures
`define FTE_EMAX 15'h7fff
`define FTE_ADJ 18'h06000
`define FTE_ETOP 18'h07fff
`endif

//--- hw/fte_core.v
// Tag word, operand classification and numeric exception unit.
// Assumes a classic Wishbone master on clk_i and a synchronous reset.
`timescale 1ns/1ps
`include "fte_regs.vh"
module fte_core (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Interrupt
  output wire irq_o
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function [2:0] fte_cls;
    input [79:0] r;
    begin
      if (r[78:64] == 15'h0000) begin
        if (r[63:0] == 64'h0) fte_cls = `FTE_CL_ZERO;
        else fte_cls = `FTE_CL_DEN;
      end else if (!r[63]) begin
        fte_cls = `FTE_CL_UNS;
      end else if (r[78:64] == `FTE_EMAX) begin
        if (r[62:0] == 63'h0) fte_cls = `FTE_CL_INF;
        else if (r[62]) fte_cls = `FTE_CL_QUIET_NAN;
        else fte_cls = `FTE_CL_SIGNALING_NAN;
      end else begin
        fte_cls = `FTE_CL_NORM;
      end
    end
  endfunction

  function [31:0] fte_wm;
    input [31:0] o;
    input [31:0] n;
    input [3:0] s;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        fte_wm[8*k +: 8] = s[k] ? n[8*k +: 8] : o[8*k +: 8];
    end
  endfunction

  // Returns {inexact, carry, rounded 66 bits}
  function [67:0] fte_rnd;
    input [65:0] x;
    input [6:0] d;
    input [1:0] rc;
    input sg;
    reg [65:0] m;
    reg [65:0] h;
    reg [65:0] dr;
    reg inc;
    begin
      m = (66'h1 << d) - 66'h1;
      h = 66'h1 << (d - 7'h1);
      dr = x & m;
      case (rc)
        2'b00: inc = (dr > h) || ((dr == h) && x[d]);
        2'b01: inc = sg && (dr != 66'h0);
        2'b10: inc = !sg && (dr != 66'h0);
        default: inc = 1'b0;
      endcase
      fte_rnd = {dr != 66'h0, {1'b0, x & ~m} + (inc ? {1'b0, m} + 67'h1 : 67'h0)};
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [79:0] fr_q [0:7];
  reg [7:0] empty_q;
  reg [11:0] ctrl_q;
  reg [6:0] stat_q;
  reg c1_q;
  reg [6:0] imask_q;
  reg [31:0] res_lo_q;
  reg [31:0] res_hi_q;
  reg [20:0] res_ex_q;
  reg [79:0] nrm_q;
  reg [2:0] last_cls_q;
  wire [15:0] tag_word;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire [31:0] wd = fte_wm(32'h0, wb_dat_i, wb_sel_i);

  // ----------------------------------------
  // Byte-lane merges for narrow registers
  // ----------------------------------------
  wire [31:0] ctrl_m = fte_wm({20'h0, ctrl_q}, wb_dat_i, wb_sel_i);
  wire [31:0] imask_m = fte_wm({25'h0, imask_q}, wb_dat_i, wb_sel_i);
  wire [31:0] rex_m = fte_wm({11'h0, res_ex_q}, wb_dat_i, wb_sel_i);
  wire [31:0] rx_m = fte_wm({16'h0, fr_q[{wb_adr_i[7], wb_adr_i[5:4]}][79:64]},
    wb_dat_i, wb_sel_i);

  // ----------------------------------------
  // Tag computation per register
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_tag
      wire [2:0] c = fte_cls(fr_q[g]);
      assign tag_word[2*g +: 2] = empty_q[g] ? `FTE_TG_EMPTY :
        (c == `FTE_CL_ZERO) ? `FTE_TG_ZERO :
        (c == `FTE_CL_NORM) ? `FTE_TG_VALID : `FTE_TG_SPEC;
    end
  endgenerate

  // ----------------------------------------
  // Command decode and operand checks
  // ----------------------------------------
  wire cmd = wr && (wb_adr_i == `FTE_CMD);
  wire [3:0] op = wb_dat_i[9:6];
  wire [2:0] ia = wb_dat_i[2:0];
  wire [2:0] ib = wb_dat_i[5:3];
  wire fixext = wb_dat_i[10];
  wire [79:0] va = fr_q[ia];
  wire [79:0] vb = fr_q[ib];
  wire [2:0] ca = fte_cls(va);
  wire [2:0] cb = fte_cls(vb);
  wire useb = (op == `FTE_OP_ARITH) || (op == `FTE_OP_CMP);
  wire chk = (op >= `FTE_OP_ARITH) && (op <= `FTE_OP_SPLIT);
  wire qop = (op == `FTE_OP_CMP) || (op == `FTE_OP_STINT) || (op == `FTE_OP_STDEC);
  wire s_uf = chk && (empty_q[ia] || (useb && empty_q[ib]));
  wire s_of = (op == `FTE_OP_PUSH) && !empty_q[ia];
  wire nan_a = (ca == `FTE_CL_QUIET_NAN) || (ca == `FTE_CL_SIGNALING_NAN);
  wire nan_b = useb && ((cb == `FTE_CL_QUIET_NAN) || (cb == `FTE_CL_SIGNALING_NAN));
  wire inv_s = (ca == `FTE_CL_SIGNALING_NAN) || (useb && (cb == `FTE_CL_SIGNALING_NAN));
  wire inv_q = qop && (nan_a || nan_b);
  wire inv_u = (ca == `FTE_CL_UNS) || (useb && (cb == `FTE_CL_UNS));
  wire inv = chk && !s_uf && (inv_s || inv_q || inv_u);
  wire den = chk && !s_uf && !inv &&
    ((ca == `FTE_CL_DEN) || (useb && (cb == `FTE_CL_DEN)));
  wire [79:0] nan_src = nan_a ? va : vb;
  wire [79:0] qres = (nan_a || nan_b) ?
    {nan_src[79:63], 1'b1, nan_src[61:0]} :
    {1'b1, `FTE_EMAX, 64'hc000000000000000};
  wire wr_nan = chk && !s_uf && (op == `FTE_OP_ARITH || op == `FTE_OP_TRANS ||
    op == `FTE_OP_SPLIT) && ((inv && ctrl_q[`FTE_IM]) || (!inv && (nan_a || nan_b)));

  // ----------------------------------------
  // Denormal normalization
  // ----------------------------------------
  reg [6:0] lz;
  integer i;
  always @* begin
    lz = 7'd64;
    for (i = 0; i < 64; i = i + 1)
      if (va[i]) lz = 7'd63 - i[6:0];
  end
  wire [63:0] nsig = va[63:0] << lz;
  wire [17:0] nexp = 18'h1 - {11'h0, lz};
  wire do_nrm = (ca == `FTE_CL_DEN) && ctrl_q[`FTE_DM];

  // ----------------------------------------
  // Result finishing: rounding, over and underflow
  // ----------------------------------------
  wire sg = res_ex_q[18];
  wire [17:0] e = res_ex_q[17:0];
  wire [65:0] x = {res_hi_q, res_lo_q, res_ex_q[20], res_ex_q[19]};
  wire [1:0] pcx = fixext ? 2'b11 : ctrl_q[`FTE_PC +: 2];
  wire [6:0] dropb = (pcx == 2'b00) ? 7'd40 : (pcx == 2'b10) ? 7'd11 : 7'd0;
  wire tiny = $signed(e) < $signed(18'h1);
  wire um = ctrl_q[`FTE_UM];
  wire om = ctrl_q[`FTE_OM];
  wire [17:0] shv = 18'h1 - e;
  wire [6:0] sh = (shv > 18'd66) ? 7'd66 : shv[6:0];
  wire [65:0] xs = x >> sh;
  wire lost = (xs << sh) != x;
  wire [65:0] xd = (tiny && um) ? {xs[65:1], xs[0] | lost} : x;
  wire [67:0] rr = fte_rnd(xd, dropb + 7'd2, ctrl_q[`FTE_RC +: 2], sg);
  wire inx = rr[67];
  wire [63:0] rs = rr[66] ? 64'h8000000000000000 : rr[65:2];
  wire [17:0] eu = (tiny && !um) ? e + `FTE_ADJ : e;
  wire [17:0] ec = eu + {17'h0, rr[66]};
  wire [17:0] eov = ec - `FTE_ADJ;
  wire ovf = !tiny && ($signed(ec) >= $signed(`FTE_ETOP));
  wire to_max = (ctrl_q[`FTE_RC +: 2] == 2'b11) ||
    (ctrl_q[`FTE_RC +: 2] == 2'b01 && !sg) || (ctrl_q[`FTE_RC +: 2] == 2'b10 && sg);
  wire [63:0] maxsig = ~((64'h1 << dropb) - 64'h1);
  reg [79:0] fin;
  reg [6:0] fset;
  always @* begin
    fin = {sg, ec[14:0], rs};
    fset = 7'h0;
    fset[`FTE_PE] = inx;
    if (x[65:2] == 64'h0) begin
      fin = {sg, 79'h0};
      fset = 7'h0;
    end else if (ovf && om) begin
      fin = to_max ? {sg, 15'h7ffe, maxsig} :
        {sg, `FTE_EMAX, 64'h8000000000000000};
      fset[`FTE_OE] = 1'b1;
      fset[`FTE_PE] = 1'b1;
    end else if (ovf) begin
      fin = {sg, eov[14:0], rs};
      fset[`FTE_OE] = 1'b1;
      fset[`FTE_PE] = 1'b1;
    end else if (tiny && um) begin
      fin = {sg, 14'h0, rs[63], rs};
      fset[`FTE_UE] = inx;
    end else if (tiny) begin
      fset[`FTE_UE] = 1'b1;
    end
  end

  // ----------------------------------------
  // Status event collection
  // ----------------------------------------
  reg [6:0] ev;
  always @* begin
    ev = 7'h0;
    if (cmd) begin
      if (s_uf || s_of) begin
        ev[`FTE_IE] = 1'b1;
        ev[`FTE_SF] = 1'b1;
      end
      ev[`FTE_IE] = ev[`FTE_IE] | inv;
      ev[`FTE_DE] = den;
      if (op == `FTE_OP_FINAL) ev = ev | fset;
    end
  end
  wire [6:0] clr = (wr && wb_adr_i == `FTE_STAT) ? wd[6:0] : 7'h0;
  assign irq_o = |(stat_q & imask_q);

  // ----------------------------------------
  // Registers and data file
  // ----------------------------------------
  integer n;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (n = 0; n < 8; n = n + 1) fr_q[n] <= 80'h0;
      empty_q <= 8'hff;
      ctrl_q <= `FTE_CTRL_RST;
      stat_q <= 7'h0;
      c1_q <= 1'b0;
      imask_q <= 7'h0;
      res_lo_q <= 32'h0;
      res_hi_q <= 32'h0;
      res_ex_q <= 21'h0;
      nrm_q <= 80'h0;
      last_cls_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
      if (cmd && (s_uf || s_of)) c1_q <= s_of;
      if (wr) begin
        case (wb_adr_i)
          `FTE_CTRL: ctrl_q <= ctrl_m[11:0];
          `FTE_IMASK: imask_q <= imask_m[6:0];
          `FTE_TAG:
            for (n = 0; n < 8; n = n + 1)
              empty_q[n] <= wd[2*n +: 2] == `FTE_TG_EMPTY;
          `FTE_RES_LO: res_lo_q <= fte_wm(res_lo_q, wb_dat_i, wb_sel_i);
          `FTE_RES_HI: res_hi_q <= fte_wm(res_hi_q, wb_dat_i, wb_sel_i);
          `FTE_RES_EX: res_ex_q <= rex_m[20:0];
          default: ;
        endcase
      end
      if (wr && wb_adr_i[7:6] == 2'b01) begin
        case (wb_adr_i[3:2])
          2'h0: fr_q[wb_adr_i[5:4]][31:0] <= fte_wm(fr_q[wb_adr_i[5:4]][31:0],
            wb_dat_i, wb_sel_i);
          2'h1: fr_q[wb_adr_i[5:4]][63:32] <= fte_wm(fr_q[wb_adr_i[5:4]][63:32],
            wb_dat_i, wb_sel_i);
          2'h2: fr_q[wb_adr_i[5:4]][79:64] <= rx_m[15:0];
          default: ;
        endcase
      end
      if (wr && wb_adr_i[7:6] == 2'b10) begin
        case (wb_adr_i[3:2])
          2'h0: fr_q[{1'b1, wb_adr_i[5:4]}][31:0] <=
            fte_wm(fr_q[{1'b1, wb_adr_i[5:4]}][31:0], wb_dat_i, wb_sel_i);
          2'h1: fr_q[{1'b1, wb_adr_i[5:4]}][63:32] <=
            fte_wm(fr_q[{1'b1, wb_adr_i[5:4]}][63:32], wb_dat_i, wb_sel_i);
          2'h2: fr_q[{1'b1, wb_adr_i[5:4]}][79:64] <=
            rx_m[15:0];
          default: ;
        endcase
      end
      if (cmd) begin
        last_cls_q <= ca;
        if (chk) begin
          if (do_nrm) nrm_q <= {va[79], nexp[14:0], nsig};
          else nrm_q <= va;
        end
        if (wr_nan) fr_q[ia] <= qres;
        if (op == `FTE_OP_FINAL) begin
          fr_q[ia] <= fin;
          empty_q[ia] <= 1'b0;
        end
        if (op == `FTE_OP_PUSH && !s_of) begin
          fr_q[ia] <= fin;
          empty_q[ia] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Wishbone answer
  // ----------------------------------------
  reg [31:0] rd;
  wire [79:0] rv = fr_q[{wb_adr_i[7], wb_adr_i[5:4]}];
  always @* begin
    rd = 32'h0;
    if (wb_adr_i[7:6] == 2'b01 || wb_adr_i[7:6] == 2'b10) begin
      case (wb_adr_i[3:2])
        2'h0: rd = rv[31:0];
        2'h1: rd = rv[63:32];
        2'h2: rd = {16'h0, rv[79:64]};
        default: rd = 32'h0;
      endcase
    end else begin
      case (wb_adr_i)
        `FTE_CTRL: rd = {20'h0, ctrl_q};
        `FTE_STAT: rd = {22'h0, c1_q, 2'h0, stat_q};
        `FTE_IMASK: rd = {25'h0, imask_q};
        `FTE_TAG: rd = {16'h0, tag_word};
        `FTE_CMD: rd = {29'h0, last_cls_q};
        `FTE_RES_LO: rd = res_lo_q;
        `FTE_RES_HI: rd = res_hi_q;
        `FTE_RES_EX: rd = {11'h0, res_ex_q};
        `FTE_NRM_LO: rd = nrm_q[31:0];
        `FTE_NRM_HI: rd = nrm_q[63:32];
        `FTE_NRM_EX: rd = {16'h0, nrm_q[79:64]};
        default: rd = 32'h0;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) wb_dat_o <= rd;
    end
  end

endmodule // fte_core

//--- tb/fte_properties.sv
// Port checker for the tag and exception unit.
// Assumes the Wishbone slave ports of fte_core.
`timescale 1ns/1ps
module fte_props (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Interrupt
  input wire irq_o
);
  // ------
  // Helpers
  // ------
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("stray ack");
  a_unmapped_zero: assert property (rd && wb_adr_i == 8'h30 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_tag_width: assert property (rd && wb_adr_i == 8'h0c |-> wb_dat_o[31:16] == 16'h0)
    else $error("tag word too wide");
  a_stat_layout: assert property (rd && wb_adr_i == 8'h04 |-> !(wb_dat_o & 32'hfffffd84))
    else $error("status bit outside layout");
  a_class_range: assert property (rd && wb_adr_i == 8'h10 |-> wb_dat_o < 32'h7)
    else $error("class out of range");
  a_irq_cause: assert property ($changed(irq_o) |-> $past(req && wb_we_i))
    else $error("irq moved without write");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> $past(req && !wb_we_i))
    else $error("read data moved");
  c_tag_read: cover property (rd && wb_adr_i == 8'h0c);
  c_irq_rise: cover property ($rose(irq_o));
  c_stack_fault: cover property (rd && wb_adr_i == 8'h04 && wb_dat_o[6]);
endmodule // fte_props
bind fte_core fte_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));

//--- tb/fte_core_tb.sv
// Self-checking bench of the tag and exception unit.
// Assumes fte_core and its register map header.
`timescale 1ns/1ps
`include "fte_regs.vh"
module fte_core_tb;
  reg clk_i = 1'h0;
  reg rst_i = 1'h1;
  reg cyc = 1'h0, stb = 1'h0, we = 1'h0;
  reg [7:0] adr = 8'h0;
  reg [31:0] dat = 32'h0, q, seed = 32'h6dc4;
  reg [3:0] sel = 4'h0;
  wire [31:0] rdat;
  wire ack, irq;
  integer failures = 0, n_checks = 0, cyc_n = 0;
  fte_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      failures = failures + 1;
      close_out;
    end
  end
  // ------
  // Model
  // ------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [82:0] rv(input integer i);
    case (i)
      0: rv = {3'h1, 16'h3fff, 32'h80000000, 32'h0};
      1: rv = {3'h2, 16'h0, 32'h0, 32'h1};
      2: rv = {3'h6, 16'h3fff, 32'h40000000, 32'h0};
      3: rv = {3'h5, 16'h7fff, 32'h80000000, 32'h1};
      4: rv = {3'h4, 16'h7fff, 32'hc0000000, 32'h0};
      5: rv = {3'h3, 16'hffff, 32'h80000000, 32'h0};
      6: rv = {3'h0, 16'h8000, 32'h0, 32'h0};
      default: rv = {3'h6, 16'h1, 32'h0, 32'h0};
    endcase
  endfunction
  function [1:0] tg(input [2:0] c);
    tg = c == 3'h0 ? 2'h1 : c == 3'h1 ? 2'h0 : 2'h2;
  endfunction
  function inv(input [2:0] c, input [3:0] op);
    inv = c == 3'h5 || c == 3'h6 || (c == 3'h4 && op > 4'h1 && op < 4'h5);
  endfunction
  function [7:0] da(input integer i, input integer k);
    da = (i < 4 ? 8'h40 + 16 * i : 8'h80 + 16 * (i - 4)) + 4 * k;
  endfunction
  // ------
  // Tasks
  // ------
  task close_out;
    begin
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hf};
      @(posedge clk_i);
      while (ack !== 1'h1) @(posedge clk_i);
      q = rdat;
      {cyc, stb} <= 2'h0;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rd(input string nm, input [7:0] a, input [31:0] e);
    begin
      wb(1'h0, a, 32'h0);
      chk(nm, e, q);
    end
  endtask
  task load_regs;
    integer i;
    reg [82:0] v;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        v = rv(i);
        wb(1'h1, da(i, 0), v[31:0]);
        wb(1'h1, da(i, 1), v[63:32]);
        wb(1'h1, da(i, 2), {16'h0, v[79:64]});
      end
      wb(1'h1, `FTE_TAG, 32'h0);
    end
  endtask
  task rst_chk;
    begin
      rst_i <= 1'h1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'h0;
      rd("ctrl", `FTE_CTRL, 32'h37f);
      rd("stat", `FTE_STAT, 32'h0);
      rd("imask", `FTE_IMASK, 32'h0);
      rd("tag_rst", `FTE_TAG, 32'hffff);
      chk("irq_rst", 32'h0, {31'h0, irq});
    end
  endtask
  task run(input [3:0] op, input [2:0] a, input [2:0] b, input [11:0] ctl);
    begin
      wb(1'h1, `FTE_CTRL, {20'h0, ctl});
      wb(1'h1, `FTE_STAT, 32'h7f);
      wb(1'h1, `FTE_CMD, {22'h0, op, b, a});
      wb(1'h0, `FTE_STAT, 32'h0);
    end
  endtask
  task fin_t(input [11:0] ctl, input [31:0] hi, input [31:0] lo, input [20:0] ex, input fx,
    input [6:0] st, input [15:0] w2, input [31:0] ehi, input [31:0] elo);
    begin
      wb(1'h1, `FTE_RES_HI, hi);
      wb(1'h1, `FTE_RES_LO, lo);
      wb(1'h1, `FTE_RES_EX, {11'h0, ex});
      wb(1'h1, `FTE_CTRL, {20'h0, ctl});
      wb(1'h1, `FTE_STAT, 32'h7f);
      wb(1'h1, `FTE_CMD, {21'h0, fx, `FTE_OP_FINAL, 6'h0});
      wb(1'h0, `FTE_STAT, 32'h0);
      chk("fin_flags", {25'h0, st}, q & 32'h7f);
      rd("fin_se", da(0, 2), {16'h0, w2});
      rd("fin_hi", da(0, 1), ehi);
      rd("fin_lo", da(0, 0), elo);
    end
  endtask
  // ------
  // Sequence
  // ------
  initial begin : main
    integer i, k, op;
    reg [82:0] va;
    reg [31:0] e;
    reg f;
    rst_chk;
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      e = 32'h0;
      wb(1'h1, `FTE_TAG, seed);
      for (k = 0; k < 8; k = k + 1) e[2*k +: 2] = &seed[2*k +: 2] ? 2'h3 : 2'h1;
      rd("tag_load", `FTE_TAG, e);
    end
    wb(1'h1, `FTE_TAG, 32'hffff);
    wb(1'h1, `FTE_IMASK, 32'h41);
    run(`FTE_OP_ARITH, 3'h0, 3'h1, 12'h37f);
    chk("sf_empty", 32'h41, q);
    chk("irq_on", 32'h1, {31'h0, irq});
    wb(1'h1, 8'h30, 32'hffffffff);
    rd("unmapped", 8'h30, 32'h0);
    wb(1'h1, `FTE_IMASK, 32'h0);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wb(1'h1, `FTE_STAT, 32'h41);
    wb(1'h1, `FTE_IMASK, 32'h41);
    chk("irq_clr", 32'h0, {31'h0, irq});
    load_regs;
    e = 32'h0;
    for (k = 0; k < 8; k = k + 1) begin
      va = rv(k);
      e[2*k +: 2] = tg(va[82:80]);
    end
    rd("tag_cls", `FTE_TAG, e);
    wb(1'h1, `FTE_CMD, {22'h0, `FTE_OP_PUSH, 6'h0});
    rd("sf_push", `FTE_STAT, 32'h241);
    wb(1'h1, `FTE_STAT, 32'h27f);
    rd("c1_ro", `FTE_STAT, 32'h200);
    for (i = 0; i < 2; i = i + 1)
      for (op = 1; op < 7; op = op + 1)
        for (k = 0; k < 8; k = k + 1) begin
          load_regs;
          va = rv(k);
          run(op[3:0], k[2:0], k == 1 ? 3'h3 : 3'h0, i ? 12'h37d : 12'h37f);
          f = inv(va[82:80], op[3:0]) || (op < 3 && k == 1);
          e = {30'h0, va[82:80] == 3'h2 && !f, f};
          chk("flags", e, q & 32'h43);
          rd("class", `FTE_CMD, {29'h0, va[82:80]});
          if ((op == 1 || op > 4) && (k == 3 || k == 4))
            rd("quiet_nan", da(k, 1), 32'hc0000000);
          if (op == 5 && k == 1) rd("norm", `FTE_NRM_HI, i ? 32'h0 : 32'h80000000);
        end
    fin_t(12'hf7f, 32'hffffffff, 32'hffffffff, 21'h047fff, 1'h0,
      7'h28, 16'hfffe, 32'hffffffff, 32'hffffffff);
    fin_t(12'h37f, 32'hffffffff, 32'hffffffff, 21'h047fff, 1'h0,
      7'h28, 16'hffff, 32'h80000000, 32'h0);
    fin_t(12'h077, 32'h80000000, 32'h1, 21'h008000, 1'h0,
      7'h28, 16'h2000, 32'h80000000, 32'h0);
    fin_t(12'h077, 32'h80000000, 32'h1, 21'h008000, 1'h1,
      7'h28, 16'h2000, 32'h80000000, 32'h1);
    fin_t(12'h37f, 32'h80000000, 32'h1, 21'h0, 1'h0,
      7'h30, 16'h0, 32'h40000000, 32'h0);
    fin_t(12'h37f, 32'h80000000, 32'h0, 21'h0, 1'h0,
      7'h0, 16'h0, 32'h40000000, 32'h0);
    fin_t(12'h06f, 32'h80000000, 32'h1, 21'h0, 1'h0,
      7'h30, 16'h6000, 32'h80000000, 32'h0);
    fin_t(12'h37f, 32'h0, 32'h0, 21'h040123, 1'h0,
      7'h0, 16'h8000, 32'h0, 32'h0);
    rst_chk;
    close_out;
  end
endmodule // fte_core_tb
